// >>> rtl/hps_defs.svh
// Constants for the host port pin select and decode block
`ifndef HPS_DEFS_SVH
`define HPS_DEFS_SVH

// ****************************************************************
// Select encodings, ready value, phase numbers and bus widths
// ****************************************************************
`define HPS_SEL_CTRL      2'h0
`define HPS_SEL_DATA_INC  2'h1
`define HPS_SEL_ADDR      2'h2
`define HPS_SEL_DATA      2'h3
`define HPS_RDY_RESET     1'h1
`define HPS_PH_STROBE     2'h1
`define HPS_PH_LAST       2'h3
`define HPS_DATA_W        8
`define HPS_WORD_W        16

`endif

// >>> rtl/hps_pkg.sv
// Types for the host port; the register type is shared by both ends, the mode type is device only
package hps_pkg;
	typedef enum logic [1:0] {
		HPS_REG_CTRL,
		HPS_REG_DATA_INC,
		HPS_REG_ADDR,
		HPS_REG_DATA
	} hps_reg_t;

	typedef enum logic {
		HPS_MODE_GPIO,
		HPS_MODE_HOST
	} hps_mode_t;
endpackage : hps_pkg

// >>> rtl/hps_if.sv
// Pin-level interface between the external host and the device port
`timescale 1ns/1ps
interface hps_if;
	logic       hc0_o;     // Host drive of control pin 0 (address strobe, low active)
	logic       hc0_oe_n;  // Host enable for control pin 0, low = drives
	logic       hc1_o;     // Host drive of control pin 1 (byte ident)
	logic       hc1_oe_n;
	logic       dev_hc0_o; // Device drive when pin is general-purpose output
	logic       dev_hc0_oe_n;
	logic       dev_hc1_o;
	logic       dev_hc1_oe_n;
	logic [1:0] reg_select;
	logic       chip_select_n;
	logic       read_write;   // 1 = read
	logic       data_strobe_1_n;
	logic       data_strobe_2_n;
	logic [7:0] hd_host_o;
	logic       hd_host_oe_n;
	logic [7:0] hd_dev_o;
	logic       hd_dev_oe_n;
	logic       ready_o;
	logic       ready_oe_n;
	logic       port_enable;

	modport device (
		input  hc0_o, hc0_oe_n, hc1_o, hc1_oe_n, reg_select, chip_select_n,
		input  read_write, data_strobe_1_n, data_strobe_2_n, hd_host_o, hd_host_oe_n,
		input  port_enable,
		output dev_hc0_o, dev_hc0_oe_n, dev_hc1_o, dev_hc1_oe_n,
		output hd_dev_o, hd_dev_oe_n, ready_o, ready_oe_n
	);
	modport host (
		output hc0_o, hc0_oe_n, hc1_o, hc1_oe_n, reg_select, chip_select_n,
		output read_write, data_strobe_1_n, data_strobe_2_n, hd_host_o, hd_host_oe_n,
		output port_enable,
		input  dev_hc0_o, dev_hc0_oe_n, dev_hc1_o, dev_hc1_oe_n,
		input  hd_dev_o, hd_dev_oe_n, ready_o, ready_oe_n
	);
endinterface : hps_if

// >>> rtl/hps_device.sv
// Device end: strap-selected pin function and host access decode
// Behaviour
// RQ1 - Strap low: pin 0 is GPIO input
// RQ2 - Strap high: pin 0 is address strobe input
// RQ3 - Address strobe latches address register
// RQ4 - Address strobe only in multiplexed mode
// RQ5 - Strap fixed when reset is released
// RQ6 - Strap low: pin 1 is GPIO input
// RQ7 - Strap high: pin 1 is byte ident
// RQ8 - Host marks first or second byte
// RQ9 - Select pins pick one of four registers
// RQ10 - Chip select low selects; high ignored
// RQ11 - Host waits for reset release
// RQ12 - Read/write pin steers the access
// RQ13 - Address and data share 8-bit bus
// RQ14 - Port enable low floats all outputs
// RQ15 - Ready floats in reset, then drives 1
// RQ16 - Data strobes move data in and out
// RQ17 - Select 00 ctrl,01 inc,10 addr,11 data
// RQ18 - Ident low first byte, high second
`timescale 1ns/1ps
`include "hps_defs.svh"
module hps_device (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_boot_strap_pin,
	hps_if.device                   port,
	output logic                    o_host_mode,
	output logic [1:0]              o_gpio_in,
	output logic [15:0]             o_host_addr_reg,
	output logic [15:0]             o_host_ctrl_reg,
	output logic [15:0]             o_host_data_reg,
	output logic                    o_wr_pulse,
	output hps_pkg::hps_reg_t       o_wr_target
);
	import hps_pkg::*;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	localparam int SW = 16;
	logic [SW-1:0] s1_ff, s2_ff, nxt_s1;
	logic          hc0_pin, hc1_pin;

	// Resolved pin levels as seen at the device pads
	always_comb begin
		hc0_pin = port.hc0_oe_n ? 1'b1 : port.hc0_o;
		hc1_pin = port.hc1_oe_n ? 1'b0 : port.hc1_o;
		nxt_s1  = {i_boot_strap_pin, port.port_enable, hc0_pin, hc1_pin,
			port.reg_select, port.chip_select_n, port.read_write,
			port.data_strobe_1_n, port.data_strobe_2_n, port.hd_host_o[5:0]};
	end

	logic [1:0] hdh_s1_ff, hdh_s2_ff;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_ff     <= '0;
			s2_ff     <= '0;
			hdh_s1_ff <= '0;
			hdh_s2_ff <= '0;
		end else begin
			s1_ff     <= nxt_s1;
			s2_ff     <= s1_ff;
			hdh_s1_ff <= port.hd_host_o[7:6];
			hdh_s2_ff <= hdh_s1_ff;
		end
	end

	logic       strap_s, en_s, as_n_s, bil_s, cs_n_s, rw_s, ds1_n_s, ds2_n_s;
	logic [1:0] sel_s;
	logic [7:0] hd_s;
	always_comb begin
		strap_s = s2_ff[15];
		en_s    = s2_ff[14];
		as_n_s  = s2_ff[13];
		bil_s   = s2_ff[12];
		sel_s   = s2_ff[11:10];
		cs_n_s  = s2_ff[9];
		rw_s    = s2_ff[8];
		ds1_n_s = s2_ff[7];
		ds2_n_s = s2_ff[6];
		hd_s    = {hdh_s2_ff, s2_ff[5:0]};
	end

	// ****************************************************************
	// Strap capture after reset release
	// ****************************************************************
	// The strap is sampled by a clocked process after release, never by the reset itself
	logic      strap_done_ff, nxt_strap_done;
	hps_mode_t mode_ff, nxt_mode;
	logic [1:0] rel_ff;
	always_comb begin
		nxt_strap_done = strap_done_ff | rel_ff[1];
		nxt_mode       = mode_ff;
		if (!strap_done_ff && rel_ff[1])
			nxt_mode = strap_s ? HPS_MODE_HOST : HPS_MODE_GPIO; // RQ5
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rel_ff        <= '0;
			strap_done_ff <= 1'b0;
			mode_ff       <= HPS_MODE_GPIO;
		end else begin
			rel_ff        <= {rel_ff[0], 1'b1};
			strap_done_ff <= nxt_strap_done;
			mode_ff       <= nxt_mode;
		end
	end

	logic host_m;
	assign host_m = (mode_ff == HPS_MODE_HOST) && strap_done_ff;

	// ****************************************************************
	// Pin direction: both control pins are inputs in either function
	// ****************************************************************
	// GPIO function comes up as input, so the device never drives the control pins
	assign port.dev_hc0_o    = 1'b0;
	assign port.dev_hc0_oe_n = 1'b1; // RQ1 RQ2
	assign port.dev_hc1_o    = 1'b0;
	assign port.dev_hc1_oe_n = 1'b1; // RQ6 RQ7
	assign o_host_mode       = host_m;
	assign o_gpio_in         = host_m ? 2'h0 : {bil_s, as_n_s}; // RQ1 RQ6

	// ****************************************************************
	// Host access decode and byte assembly
	// ****************************************************************
	function automatic hps_reg_t dec_sel(input logic [1:0] s);
		case (s)
			`HPS_SEL_CTRL:     dec_sel = HPS_REG_CTRL;
			`HPS_SEL_DATA_INC: dec_sel = HPS_REG_DATA_INC;
			`HPS_SEL_ADDR:     dec_sel = HPS_REG_ADDR;
			default:           dec_sel = HPS_REG_DATA;
		endcase
	endfunction : dec_sel

	logic        ds_n, ds_prev_ff, as_prev_ff, nxt_ds_prev, nxt_as_prev;
	logic        ds_fall, ds_rise, as_fall, active;
	logic [7:0]  lo_ff, nxt_lo;
	logic [15:0] addr_ff, ctrl_ff, data_ff, nxt_addr, nxt_ctrl, nxt_data;
	logic [7:0]  rd_ff, nxt_rd;
	logic        rd_oe_ff, nxt_rd_oe, wr_ff, nxt_wr;
	hps_reg_t    tgt_ff, nxt_tgt, tgt;

	always_comb begin
		ds_n        = ds1_n_s ^ ds2_n_s ? 1'b0 : ds1_n_s; // strobe is the AND of both, low when either is low
		active      = host_m && en_s && !cs_n_s; // RQ10 RQ14
		nxt_ds_prev = ds_n;
		nxt_as_prev = as_n_s;
		ds_fall     = ds_prev_ff && !ds_n && active;
		ds_rise     = !ds_prev_ff && ds_n && active;
		as_fall     = as_prev_ff && !as_n_s && active; // RQ4
		tgt         = dec_sel(sel_s); // RQ9 RQ17
		nxt_lo      = lo_ff;
		nxt_addr    = addr_ff;
		nxt_ctrl    = ctrl_ff;
		nxt_data    = data_ff;
		nxt_rd      = rd_ff;
		nxt_rd_oe   = rd_oe_ff && active;
		nxt_wr      = 1'b0;
		nxt_tgt     = tgt_ff;
		// Address strobe: latch one address byte from the bus, low or high as byte ident picks
		if (as_fall) begin
			if (!bil_s) nxt_addr[7:0]  = hd_s; // RQ3 RQ18
			else        nxt_addr[15:8] = hd_s;
		end
		if (ds_fall && rw_s) begin // RQ12
			nxt_rd_oe = 1'b1;
			case (tgt)
				HPS_REG_CTRL: nxt_rd = bil_s ? ctrl_ff[15:8] : ctrl_ff[7:0];
				HPS_REG_ADDR: nxt_rd = bil_s ? addr_ff[15:8] : addr_ff[7:0];
				default:      nxt_rd = bil_s ? data_ff[15:8] : data_ff[7:0];
			endcase
		end
		// Writes take effect when the strobe rises; second byte commits the word
		if (ds_rise) begin
			nxt_rd_oe = 1'b0;
			if (!rw_s) begin
				if (!bil_s) begin
					nxt_lo = hd_s; // RQ13 RQ18
				end else begin
					nxt_wr  = 1'b1;
					nxt_tgt = tgt;
					case (tgt)
						HPS_REG_CTRL: nxt_ctrl = {hd_s, lo_ff};
						HPS_REG_ADDR: nxt_addr = {hd_s, lo_ff};
						default:      nxt_data = {hd_s, lo_ff};
					endcase
				end
			end
			// Autoincrement after the second byte of a data-increment access
			if (bil_s && tgt == HPS_REG_DATA_INC)
				nxt_addr = nxt_addr + 16'h0001;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ds_prev_ff <= 1'b1;
			as_prev_ff <= 1'b1;
			lo_ff      <= '0;
			addr_ff    <= '0;
			ctrl_ff    <= '0;
			data_ff    <= '0;
			rd_ff      <= '0;
			rd_oe_ff   <= 1'b0;
			wr_ff      <= 1'b0;
			tgt_ff     <= HPS_REG_CTRL;
		end else begin
			ds_prev_ff <= nxt_ds_prev;
			as_prev_ff <= nxt_as_prev;
			lo_ff      <= nxt_lo;
			addr_ff    <= nxt_addr;
			ctrl_ff    <= nxt_ctrl;
			data_ff    <= nxt_data;
			rd_ff      <= nxt_rd;
			rd_oe_ff   <= nxt_rd_oe;
			wr_ff      <= nxt_wr;
			tgt_ff     <= nxt_tgt;
		end
	end

	// ****************************************************************
	// Outputs toward the host
	// ****************************************************************
	// Ready floats in reset and whenever the port is disabled
	assign port.ready_o     = `HPS_RDY_RESET; // RQ15
	assign port.ready_oe_n  = !(strap_done_ff && host_m && en_s); // RQ14 RQ15
	assign port.hd_dev_o    = rd_ff;
	assign port.hd_dev_oe_n = !(rd_oe_ff && en_s); // RQ14
	assign o_host_addr_reg  = addr_ff;
	assign o_host_ctrl_reg  = ctrl_ff;
	assign o_host_data_reg  = data_ff;
	assign o_wr_pulse       = wr_ff;
	assign o_wr_target      = tgt_ff;
endmodule : hps_device

// >>> rtl/hps_host.sv
// Host end: drives one two-byte cycle per request onto the multiplexed port
`timescale 1ns/1ps
`include "hps_defs.svh"
module hps_host (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_dev_out_of_reset,
	input  wire logic               i_enable,
	input  wire logic               i_req,
	input  wire logic               i_read,
	input  wire hps_pkg::hps_reg_t  i_target,
	input  wire logic [15:0]        i_addr,
	input  wire logic [15:0]        i_wdata,
	hps_if.host                     port,
	output logic                    o_busy,
	output logic                    o_done,
	output logic [15:0]             o_rdata
);
	import hps_pkg::*;

	// ****************************************************************
	// Sequencer: address bytes, then two data bytes
	// ****************************************************************
	typedef enum {ST_IDLE, ST_ADDR, ST_STROBE, ST_RELEASE, ST_DONE} hps_st_t;
	hps_st_t     st_ff, nxt_st;
	logic [1:0]  ph_ff, nxt_ph;  // Phase counter within a state
	logic        byte_ff, nxt_byte;
	logic        rd_ff, nxt_rd;
	hps_reg_t    tgt_ff, nxt_tgt;
	logic [15:0] a_ff, nxt_a, w_ff, nxt_w, r_ff, nxt_r;
	logic        done_ff, nxt_done;
	logic [1:0]  go_s1_ff, go_s2_ff; // Synchronised reset release and device data enable
	logic [7:0]  hd_s1_ff, hd_s2_ff;

	// Bus pins come from the device domain, so pass two flops before use
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			go_s1_ff <= '0;
			go_s2_ff <= '0;
			hd_s1_ff <= '0;
			hd_s2_ff <= '0;
		end else begin
			go_s1_ff <= {i_dev_out_of_reset, port.hd_dev_oe_n};
			go_s2_ff <= go_s1_ff;
			hd_s1_ff <= port.hd_dev_o;
			hd_s2_ff <= hd_s1_ff;
		end
	end

	// Phases last four cycles so the device's two-flop sampling sees each level
	always_comb begin
		nxt_st   = st_ff;
		nxt_ph   = ph_ff + 2'h1;
		nxt_byte = byte_ff;
		nxt_rd   = rd_ff;
		nxt_tgt  = tgt_ff;
		nxt_a    = a_ff;
		nxt_w    = w_ff;
		nxt_r    = r_ff;
		nxt_done = 1'b0;
		case (st_ff)
			ST_IDLE: begin
				nxt_ph = '0;
				if (i_req && go_s2_ff[1]) begin // RQ11
					nxt_st   = ST_ADDR;
					nxt_byte = 1'b0;
					nxt_rd   = i_read;
					nxt_tgt  = i_target;
					nxt_a    = i_addr;
					nxt_w    = i_wdata;
				end
			end
			ST_ADDR: if (ph_ff == `HPS_PH_LAST) begin
				nxt_byte = !byte_ff;
				if (byte_ff) nxt_st = ST_STROBE;
			end
			ST_STROBE: if (ph_ff == `HPS_PH_LAST) begin
				nxt_st = ST_RELEASE;
			end
			// Read byte is taken late in release: the device answers three cycles after
			// the strobe falls and holds the byte, so the strobe phase alone is too short
			ST_RELEASE: if (ph_ff == `HPS_PH_LAST) begin
				if (rd_ff && !go_s2_ff[0]) begin
					if (byte_ff) nxt_r[15:8] = hd_s2_ff;
					else         nxt_r[7:0]  = hd_s2_ff;
				end
				nxt_byte = !byte_ff;
				nxt_st   = byte_ff ? ST_DONE : ST_STROBE; // RQ8 RQ13
			end
			ST_DONE: begin
				nxt_done = 1'b1;
				nxt_st   = ST_IDLE;
			end
			default: nxt_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff   <= ST_IDLE;
			ph_ff   <= '0;
			byte_ff <= 1'b0;
			rd_ff   <= 1'b0;
			tgt_ff  <= HPS_REG_CTRL;
			a_ff    <= '0;
			w_ff    <= '0;
			r_ff    <= '0;
			done_ff <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			ph_ff   <= nxt_ph;
			byte_ff <= nxt_byte;
			rd_ff   <= nxt_rd;
			tgt_ff  <= nxt_tgt;
			a_ff    <= nxt_a;
			w_ff    <= nxt_w;
			r_ff    <= nxt_r;
			done_ff <= nxt_done;
		end
	end

	// ****************************************************************
	// Pin drive
	// ****************************************************************
	logic in_cyc;
	assign in_cyc             = (st_ff != ST_IDLE);
	assign port.port_enable   = i_enable;
	assign port.chip_select_n = !in_cyc; // RQ10
	assign port.read_write    = rd_ff; // RQ12
	assign port.reg_select    = tgt_ff;
	assign port.hc0_o         = !(st_ff == ST_ADDR && ph_ff == `HPS_PH_STROBE); // RQ3
	assign port.hc0_oe_n      = 1'b0;
	assign port.hc1_o         = byte_ff; // RQ8
	assign port.hc1_oe_n      = 1'b0;
	assign port.data_strobe_1_n = !(st_ff == ST_STROBE); // RQ16
	assign port.data_strobe_2_n = 1'b1;
	assign port.hd_host_o     = (st_ff == ST_ADDR) ? (byte_ff ? a_ff[15:8] : a_ff[7:0])
	                                               : (byte_ff ? w_ff[15:8] : w_ff[7:0]);
	assign port.hd_host_oe_n  = rd_ff && st_ff != ST_ADDR;
	assign o_busy             = in_cyc;
	assign o_done             = done_ff;
	assign o_rdata            = r_ff;
endmodule : hps_host

// >>> verif/hps_chk.sv
// Pin-level checker for the multiplexed host port
`timescale 1ns/1ps
module hps_chk (
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic       hc0_o,
	input wire logic       hc0_oe_n,
	input wire logic       dev_hc0_oe_n,
	input wire logic       dev_hc1_oe_n,
	input wire logic       chip_select_n,
	input wire logic       read_write,
	input wire logic       data_strobe_1_n,
	input wire logic [7:0] hd_host_o,
	input wire logic       hd_host_oe_n,
	input wire logic       hd_dev_oe_n,
	input wire logic       ready_o,
	input wire logic       ready_oe_n,
	input wire logic       port_enable
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// ****************
	// Steps of a host cycle
	// ****************
	// Ready low-impedance means host mode and enabled
	sequence rd_fall_s;
		$fell(data_strobe_1_n) && read_write && !chip_select_n && !ready_oe_n;
	endsequence
	sequence as_fall_s;
		$fell(hc0_o) && !hc0_oe_n;
	endsequence
	// ****************
	// Assertions
	// ****************
	ctl_in_a: assert property (dev_hc0_oe_n && dev_hc1_oe_n)
		else $error("control pin driven by device");
	// Enable passes the device's two-flop sync, so outputs float by the third low sample
	port_off_a: assert property ((!port_enable) [*3] |-> ready_oe_n && hd_dev_oe_n)
		else $error("disabled port drives a pin");
	rdy_one_a: assert property (!ready_oe_n |-> ready_o)
		else $error("ready driven low");
	// Sync delay lets a read release late, hence the run of eight
	cs_ignore_a: assert property (chip_select_n [*8] |-> hd_dev_oe_n)
		else $error("unselected port drives data");
	wr_quiet_a: assert property ((!read_write) [*8] |-> hd_dev_oe_n)
		else $error("device drives data in a write");
	bus_share_a: assert property (hd_dev_oe_n || hd_host_oe_n)
		else $error("both ends drive data bus");
	addr_hold_a: assert property (as_fall_s |-> !hd_host_oe_n ##1 ($stable(hd_host_o)) [*2])
		else $error("address moved under strobe");
	rd_drive_a: assert property (rd_fall_s |-> ##[3:5] !hd_dev_oe_n)
		else $error("read data not driven");
endmodule : hps_chk

// >>> verif/tb_top.sv
// Testbench joining host and device ends of the host port
`timescale 1ns/1ps
module tb_top;
	import hps_pkg::*;
	logic        clk   = 0;
	logic        rst   = 1;
	logic        strap = 0;
	logic        en    = 1;
	logic        req   = 0;
	logic        rd    = 0;
	hps_reg_t    tgt   = HPS_REG_CTRL;
	logic [15:0] adr   = 16'h0;
	logic [15:0] wd    = 16'h0;
	logic [15:0] ctl, dat, rdat, ad;
	logic        mode, busy, done, wp;
	logic [1:0]  gin;
	hps_reg_t    wt;
	int          errors   = 0;
	int          compares = 0;
	int          wcnt     = 0;
	// 50 MHz clock
	always #10 clk = ~clk;
	hps_if bus();
	hps_device hps_device_inst (.i_clk(clk), .i_rst(rst), .i_boot_strap_pin(strap),
		.port(bus), .o_host_mode(mode), .o_gpio_in(gin), .o_host_addr_reg(ad),
		.o_host_ctrl_reg(ctl), .o_host_data_reg(dat), .o_wr_pulse(wp), .o_wr_target(wt));
	hps_host hps_host_inst (.i_clk(clk), .i_rst(rst), .i_dev_out_of_reset(!rst),
		.i_enable(en), .i_req(req), .i_read(rd), .i_target(tgt), .i_addr(adr),
		.i_wdata(wd), .port(bus), .o_busy(busy), .o_done(done), .o_rdata(rdat));
	hps_chk hps_chk_inst (.i_clk(clk), .i_rst(rst), .hc0_o(bus.hc0_o),
		.hc0_oe_n(bus.hc0_oe_n), .dev_hc0_oe_n(bus.dev_hc0_oe_n),
		.dev_hc1_oe_n(bus.dev_hc1_oe_n), .chip_select_n(bus.chip_select_n),
		.read_write(bus.read_write), .data_strobe_1_n(bus.data_strobe_1_n),
		.hd_host_o(bus.hd_host_o), .hd_host_oe_n(bus.hd_host_oe_n),
		.hd_dev_oe_n(bus.hd_dev_oe_n), .ready_o(bus.ready_o),
		.ready_oe_n(bus.ready_oe_n), .port_enable(bus.port_enable));
	// Count committed words
	always @(posedge clk) begin
		if (wp === 1'b1) wcnt <= wcnt + 1;
	end
	// ****************
	// Tasks
	// ****************
	task summarize;
		if (errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Strap is set as reset asserts, ahead of release, so its synchroniser settles in time
	task do_rst(input logic s);
		@(negedge clk);
		rst = 1;
		strap = s;
		repeat (2) @(negedge clk);
		chk(16'(bus.ready_oe_n), 16'h1);
		repeat (2) @(negedge clk);
		rst = 0;
		repeat (8) @(negedge clk);
	endtask : do_rst
	// One two-byte host cycle; w says whether a word commit is due
	task xfer(input logic r, input hps_reg_t t, input logic [15:0] a,
		input logic [15:0] d, input logic w);
		int n;
		int c0;
		c0 = wcnt;
		n = 0;
		@(negedge clk);
		req = 1;
		rd = r;
		tgt = t;
		adr = a;
		wd = d;
		@(negedge clk);
		while (busy !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		req = 0;
		while (done !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(16'(done), 16'h1);
		// Margin for the device's two-flop input path
		repeat (6) @(negedge clk);
		chk(16'(wcnt - c0), 16'(w));
	endtask : xfer
	// ****************
	// Tests
	// ****************
	initial begin
		do_rst(0);
		chk(16'(mode), 16'h0);
		chk(16'(bus.ready_oe_n), 16'h1);
		xfer(0, HPS_REG_CTRL, 16'h1234, 16'hA55A, 0);
		chk(ad, 16'h0000);
		// Idle host leaves strobe high and ident low, seen as plain inputs
		chk(16'(gin), 16'h1);
		do_rst(1);
		chk(16'(mode), 16'h1);
		chk(16'(gin), 16'h0);
		chk(16'({bus.ready_oe_n, bus.ready_o}), 16'h1);
		// Strap moves after release must not change the mode
		strap = 0;
		xfer(0, HPS_REG_ADDR, 16'h0F0F, 16'h1357, 1);
		chk(ad, 16'h1357);
		chk(16'(wt), 16'(HPS_REG_ADDR));
		xfer(0, HPS_REG_CTRL, 16'h2000, 16'hC3A5, 1);
		chk(ctl, 16'hC3A5);
		chk(ad, 16'h2000);
		xfer(0, HPS_REG_DATA, 16'h00FF, 16'hBEEF, 1);
		chk(dat, 16'hBEEF);
		chk(ad, 16'h00FF);
		// Increment carries from the low byte into the high byte
		xfer(0, HPS_REG_DATA_INC, 16'h12FF, 16'h5AA5, 1);
		chk(dat, 16'h5AA5);
		chk(ad, 16'h1300);
		chk(16'(wt), 16'(HPS_REG_DATA_INC));
		xfer(1, HPS_REG_CTRL, 16'h0000, 16'h0000, 0);
		chk(rdat, 16'hC3A5);
		xfer(1, HPS_REG_DATA, 16'h0000, 16'h0000, 0);
		chk(rdat, 16'h5AA5);
		chk(16'(mode), 16'h1);
		en = 0;
		xfer(0, HPS_REG_CTRL, 16'h0000, 16'h0001, 0);
		chk(ctl, 16'hC3A5);
		chk(16'({bus.ready_oe_n, bus.hd_dev_oe_n}), 16'h3);
		summarize;
	end
	// Whole run is near 280 cycles; this cuts a hang
	initial begin
		#100000;
		errors++;
		summarize;
	end
endmodule : tb_top
